/* lir_consts.vh */
`ifndef LIR_CONSTS_VH
`define LIR_CONSTS_VH

// Direct register addresses on the special-function bus
`define LIR_SFR_CFG 8'hc9
`define LIR_SFR_DAT 8'hd2
`define LIR_SFR_ADR 8'hd3

// Indirect register indices
`define LIR_IDX_BYTE_FIRST 8'h00
`define LIR_IDX_BYTE_LAST 8'h07
`define LIR_IDX_CTRL 8'h08
`define LIR_IDX_STAT 8'h09
`define LIR_IDX_ERR 8'h0a
`define LIR_IDX_SIZE 8'h0b
`define LIR_IDX_DIV 8'h0c
`define LIR_IDX_MUL 8'h0d
`define LIR_IDX_ID 8'h0e

// Reset values
`define LIR_CFG_RST 8'h60
`define LIR_PTR_RST 8'h00
`define LIR_CTRL_RST 8'h00
`define LIR_SIZE_RST 8'h00
`define LIR_DIV_RST 8'h00
`define LIR_MUL_RST 8'h00
`define LIR_ID_RST 8'h00

// Mode register fields
`define LIR_CFG_EN 7
`define LIR_CFG_MASTER 6
`define LIR_CFG_AUTO_BAUD_SELECT 5
`define LIR_CFG_WMASK 8'he0

// Control register fields
`define LIR_CTRL_STOP 7
`define LIR_CTRL_DTACK 4
`define LIR_CTRL_CLRINT 3
`define LIR_CTRL_CLRERR 2
`define LIR_CTRL_WUPREQ 1
`define LIR_CTRL_STREQ 0
`define LIR_CTRL_STORED 8'h73

// Bits that exist per register and per mode
`define LIR_CTRL_AV_MASTER 8'h2f
`define LIR_CTRL_AV_SLAVE 8'hfe
`define LIR_STAT_AV_MASTER 8'hcf
`define LIR_STAT_AV_SLAVE 8'hff
`define LIR_ERR_AV_MASTER 8'h07
`define LIR_ERR_AV_SLAVE 8'h1f
`define LIR_SIZE_AV 8'h8f
`define LIR_ID_AV 8'h3f
`define LIR_FULL_AV 8'hff

`endif

/* lir_frame_buf.v */
`timescale 1ns/100ps
`default_nettype none

// Frame data bytes; software port wins a same-address write clash
module lir_frame_buf #(
	parameter AW = 3,
	parameter DW = 8
)
(
	input wire i_clk_sys,
	input wire i_nrst,
	input wire i_cpu_we,
	input wire [AW-1:0] i_cpu_waddr,
	input wire [DW-1:0] i_cpu_wdata,
	input wire [AW-1:0] i_cpu_raddr,
	output reg [DW-1:0] o_cpu_rdata,
	input wire i_eng_we,
	input wire [AW-1:0] i_eng_waddr,
	input wire [DW-1:0] i_eng_wdata,
	input wire [AW-1:0] i_eng_raddr,
	output reg [DW-1:0] o_eng_rdata
);

	localparam DEPTH = 1 << AW;

	reg [DW-1:0] mem [0:DEPTH-1];
	integer k;

	always @(posedge i_clk_sys or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			for (k = 0; k < DEPTH; k = k + 1)
				mem[k] <= {DW{1'b0}};
			o_cpu_rdata <= {DW{1'b0}};
			o_eng_rdata <= {DW{1'b0}};
		end
		else
		begin
			if (i_eng_we)
				mem[i_eng_waddr] <= i_eng_wdata;
			if (i_cpu_we)
				mem[i_cpu_waddr] <= i_cpu_wdata;
			o_cpu_rdata <= mem[i_cpu_raddr];
			o_eng_rdata <= mem[i_eng_raddr];
		end
	end

endmodule

`default_nettype wire

/* lir_indirect_regs.v */
`timescale 1ns/100ps
`default_nettype none
`include "lir_consts.vh"

module lir_indirect_regs #(
	parameter BYTE_AW = 3
)
(
	input wire i_clk_sys,
	input wire i_nrst,
	input wire [7:0] i_sfr_addr,
	input wire [7:0] i_sfr_wdata,
	input wire i_sfr_wr,
	input wire i_sfr_rd,
	output reg [7:0] o_sfr_rdata,
	output reg o_sfr_rvalid,
	output reg o_controller_enable,
	output reg o_master_mode,
	output reg o_auto_baud_select,
	output reg o_auto_baud_active,
	output reg [7:0] o_frame_control,
	output reg o_stop_strobe,
	output reg o_clear_interrupt_strobe,
	output reg o_clear_error_strobe,
	input wire i_streq_done,
	input wire i_dtack_done,
	input wire i_wupreq_done,
	input wire [7:0] i_frame_status,
	input wire [7:0] i_frame_error_flags,
	output reg [7:0] o_frame_length_checksum,
	output reg [7:0] o_baud_divider_low,
	output reg [7:0] o_baud_multiplier_prescale,
	output reg [7:0] o_frame_identifier,
	input wire [BYTE_AW-1:0] i_eng_rd_addr,
	output wire [7:0] o_eng_rd_data,
	input wire i_eng_wr,
	input wire [BYTE_AW-1:0] i_eng_wr_addr,
	input wire [7:0] i_eng_wr_data
);

	// fifteen indexed registers
	// Bits of an indirect register that exist in the given mode
	function [7:0] avail_mask;
		input [7:0] idx;
		input master;
		begin
			case (idx)
				`LIR_IDX_CTRL:
					avail_mask = master ? `LIR_CTRL_AV_MASTER
						: `LIR_CTRL_AV_SLAVE;
				`LIR_IDX_STAT:
					avail_mask = master ? `LIR_STAT_AV_MASTER
						: `LIR_STAT_AV_SLAVE;
				`LIR_IDX_ERR:
					avail_mask = master ? `LIR_ERR_AV_MASTER
						: `LIR_ERR_AV_SLAVE;
				`LIR_IDX_SIZE:
					avail_mask = `LIR_SIZE_AV;
				`LIR_IDX_DIV,
				`LIR_IDX_MUL:
					avail_mask = `LIR_FULL_AV;
				`LIR_IDX_ID:
					avail_mask = `LIR_ID_AV;
				default:
					avail_mask = (idx <= `LIR_IDX_BYTE_LAST) ?
						`LIR_FULL_AV : 8'h00;
			endcase
		end
	endfunction

	// Masked register update: only available bits take new data
	function [7:0] merge;
		input [7:0] old;
		input [7:0] wd;
		input [7:0] mask;
		begin
			merge = (old & ~mask) | (wd & mask);
		end
	endfunction

	reg [7:0] ptr_r;
	reg [7:0] ptr_nxt;
	reg [7:0] cfg_r;
	reg [7:0] cfg_nxt;
	reg [7:0] ctrl_nxt;
	reg [7:0] size_nxt;
	reg [7:0] div_nxt;
	reg [7:0] mul_nxt;
	reg [7:0] id_nxt;
	reg stop_nxt;
	reg clrint_nxt;
	reg clrerr_nxt;
	reg rd_pend_r;
	reg rd_buf_r;
	reg [7:0] rd_misc_r;
	reg [7:0] misc_val;
	reg rd_is_buf;

	wire master;
	wire [7:0] av;
	wire dat_wr;
	wire dat_rd;
	wire idx_is_byte;
	wire buf_we;
	wire [7:0] buf_q;

	assign master = cfg_r[`LIR_CFG_MASTER];
	assign av = avail_mask(ptr_r, master);
	assign dat_wr = i_sfr_wr && (i_sfr_addr == `LIR_SFR_DAT);
	assign dat_rd = i_sfr_rd && (i_sfr_addr == `LIR_SFR_DAT);
	assign idx_is_byte = (ptr_r <= `LIR_IDX_BYTE_LAST);
	assign buf_we = dat_wr && idx_is_byte;

	lir_frame_buf #(
		.AW(BYTE_AW),
		.DW(8)
	) u_buf (
		.i_clk_sys(i_clk_sys),
		.i_nrst(i_nrst),
		.i_cpu_we(buf_we),
		.i_cpu_waddr(ptr_r[BYTE_AW-1:0]),
		.i_cpu_wdata(i_sfr_wdata),
		.i_cpu_raddr(ptr_r[BYTE_AW-1:0]),
		.o_cpu_rdata(buf_q),
		.i_eng_we(i_eng_wr),
		.i_eng_waddr(i_eng_wr_addr),
		.i_eng_wdata(i_eng_wr_data),
		.i_eng_raddr(i_eng_rd_addr),
		.o_eng_rdata(o_eng_rd_data)
	);

	// Direct registers and write side effects
	always @*
	begin
		ptr_nxt = ptr_r;
		cfg_nxt = cfg_r;
		ctrl_nxt = o_frame_control;
		size_nxt = o_frame_length_checksum;
		div_nxt = o_baud_divider_low;
		mul_nxt = o_baud_multiplier_prescale;
		id_nxt = o_frame_identifier;
		stop_nxt = 1'b0;
		clrint_nxt = 1'b0;
		clrerr_nxt = 1'b0;
		// Engine hands back the self-clearing request bits
		if (i_streq_done)
			ctrl_nxt[`LIR_CTRL_STREQ] = 1'b0;
		if (i_dtack_done)
			ctrl_nxt[`LIR_CTRL_DTACK] = 1'b0;
		if (i_wupreq_done)
			ctrl_nxt[`LIR_CTRL_WUPREQ] = 1'b0;
		if (i_sfr_wr && (i_sfr_addr == `LIR_SFR_ADR))
			ptr_nxt = i_sfr_wdata;
		// enable, mode and baud bits; low bits stay zero
		if (i_sfr_wr && (i_sfr_addr == `LIR_SFR_CFG))
			cfg_nxt = i_sfr_wdata & `LIR_CFG_WMASK;
		// store through the data port; unmapped fall to default, nothing stored
		if (dat_wr)
		begin
			case (ptr_r)
				`LIR_IDX_CTRL:
				begin
					// Software set wins over a same-cycle engine clear
					ctrl_nxt = merge(ctrl_nxt, i_sfr_wdata,
						av & `LIR_CTRL_STORED);
					stop_nxt = i_sfr_wdata[`LIR_CTRL_STOP]
						& av[`LIR_CTRL_STOP];
					clrint_nxt = i_sfr_wdata[`LIR_CTRL_CLRINT];
					clrerr_nxt = i_sfr_wdata[`LIR_CTRL_CLRERR];
				end
				`LIR_IDX_SIZE:
					size_nxt = merge(size_nxt, i_sfr_wdata, av);
				`LIR_IDX_DIV:
					div_nxt = merge(div_nxt, i_sfr_wdata, av);
				`LIR_IDX_MUL:
					mul_nxt = merge(mul_nxt, i_sfr_wdata, av);
				`LIR_IDX_ID:
					id_nxt = merge(id_nxt, i_sfr_wdata, av);
				default:
					id_nxt = o_frame_identifier;
			endcase
		end
	end

	// value of the selected register when the read is taken
	always @*
	begin
		rd_is_buf = 1'b0;
		misc_val = 8'h00;
		case (i_sfr_addr)
			`LIR_SFR_ADR:
				misc_val = ptr_r;
			`LIR_SFR_CFG:
				misc_val = cfg_r;
			`LIR_SFR_DAT:
			begin
				rd_is_buf = idx_is_byte;
				case (ptr_r)
					// strobe bits never stored, read zero
					`LIR_IDX_CTRL:
						misc_val = o_frame_control & av;
					`LIR_IDX_STAT:
						misc_val = i_frame_status & av;
					`LIR_IDX_ERR:
						misc_val = i_frame_error_flags & av;
					`LIR_IDX_SIZE:
						misc_val = o_frame_length_checksum & av;
					`LIR_IDX_DIV:
						misc_val = o_baud_divider_low;
					`LIR_IDX_MUL:
						misc_val = o_baud_multiplier_prescale;
					`LIR_IDX_ID:
						misc_val = o_frame_identifier & av;
					// beyond the last index reads zero
					default:
						misc_val = 8'h00;
				endcase
			end
			default:
				misc_val = 8'h00;
		endcase
	end

	always @(posedge i_clk_sys or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			ptr_r <= `LIR_PTR_RST;
			cfg_r <= `LIR_CFG_RST;
			o_controller_enable <= 1'b0;
			o_master_mode <= 1'b1;
			o_auto_baud_select <= 1'b1;
			o_auto_baud_active <= 1'b0;
			o_frame_control <= `LIR_CTRL_RST;
			o_stop_strobe <= 1'b0;
			o_clear_interrupt_strobe <= 1'b0;
			o_clear_error_strobe <= 1'b0;
			o_frame_length_checksum <= `LIR_SIZE_RST;
			o_baud_divider_low <= `LIR_DIV_RST;
			o_baud_multiplier_prescale <= `LIR_MUL_RST;
			o_frame_identifier <= `LIR_ID_RST;
			rd_pend_r <= 1'b0;
			rd_buf_r <= 1'b0;
			rd_misc_r <= 8'h00;
			o_sfr_rdata <= 8'h00;
			o_sfr_rvalid <= 1'b0;
		end
		else
		begin
			ptr_r <= ptr_nxt;
			cfg_r <= cfg_nxt;
			o_controller_enable <= cfg_nxt[`LIR_CFG_EN];
			o_master_mode <= cfg_nxt[`LIR_CFG_MASTER];
			o_auto_baud_select <= cfg_nxt[`LIR_CFG_AUTO_BAUD_SELECT];
			o_auto_baud_active <= cfg_nxt[`LIR_CFG_AUTO_BAUD_SELECT]
				& ~cfg_nxt[`LIR_CFG_MASTER];
			o_frame_control <= ctrl_nxt;
			o_stop_strobe <= stop_nxt;
			o_clear_interrupt_strobe <= clrint_nxt;
			o_clear_error_strobe <= clrerr_nxt;
			o_frame_length_checksum <= size_nxt;
			o_baud_divider_low <= div_nxt;
			o_baud_multiplier_prescale <= mul_nxt;
			o_frame_identifier <= id_nxt;
			// Two-stage read: buffer byte arrives one edge later
			rd_pend_r <= i_sfr_rd;
			rd_buf_r <= rd_is_buf;
			rd_misc_r <= misc_val;
			o_sfr_rvalid <= rd_pend_r;
			if (rd_pend_r)
				o_sfr_rdata <= rd_buf_r ? buf_q : rd_misc_r;
		end
	end

endmodule

`default_nettype wire

/* lir_regs_properties.sv */
`timescale 1ns/100ps
`default_nettype none
module lir_regs_properties (
	input wire i_clk_sys,
	input wire i_nrst,
	input wire [7:0] i_sfr_addr,
	input wire [7:0] i_sfr_wdata,
	input wire i_sfr_wr,
	input wire i_sfr_rd,
	input wire o_sfr_rvalid,
	input wire o_controller_enable,
	input wire o_master_mode,
	input wire o_auto_baud_select,
	input wire o_auto_baud_active,
	input wire [7:0] o_frame_control,
	input wire o_stop_strobe,
	input wire o_clear_interrupt_strobe,
	input wire [7:0] o_frame_length_checksum,
	input wire [7:0] o_frame_identifier
);
	default clocking @(posedge i_clk_sys);
	endclocking
	default disable iff (!i_nrst);
	sequence cfg_wr;
		i_sfr_wr && i_sfr_addr == 8'hc9;
	endsequence
	sequence rd_req;
		i_sfr_rd;
	endsequence
	rd_latency_a:
	assert property (rd_req |-> ##2 o_sfr_rvalid)
		else $error("read answer not two cycles after request");
	rvalid_cause_a:
	assert property (o_sfr_rvalid |-> $past(i_sfr_rd, 2))
		else $error("read answer without request");
	mode_write_a:
	assert property (cfg_wr |=> {o_controller_enable, o_master_mode,
		o_auto_baud_select} == $past(i_sfr_wdata[7:5]))
		else $error("mode bits not taken from write");
	mode_hold_a:
	assert property (!i_sfr_wr |=> $stable(o_master_mode))
		else $error("mode changed without write");
	auto_baud_select_gate_a:
	assert property (o_auto_baud_active
		== (o_auto_baud_select && !o_master_mode))
		else $error("auto baud active outside slave selection");
	ctrl_zero_a:
	assert property ((o_frame_control & 8'h8c) == 8'h00)
		else $error("strobe bits stored in control");
	stop_slave_a:
	assert property (o_stop_strobe |-> !o_master_mode
		&& $past(i_sfr_wr && i_sfr_wdata[7]))
		else $error("stop strobe in master mode or without write");
	clr_cause_a:
	assert property (o_clear_interrupt_strobe |-> $past(i_sfr_wr
		&& i_sfr_addr == 8'hd2 && i_sfr_wdata[3]))
		else $error("interrupt clear without write");
	unused_zero_a:
	assert property ((o_frame_identifier & 8'hc0) == 8'h00
		&& (o_frame_length_checksum & 8'h70) == 8'h00)
		else $error("unavailable bits hold ones");
endmodule
bind lir_indirect_regs lir_regs_properties u_props (.*);
`default_nettype wire

/* testbench.sv */
`timescale 1ns/100ps
`default_nettype none
module testbench;
	logic i_clk_sys, i_nrst, sfr_wr, sfr_rd, eng_wr, rvalid;
	logic en, mst, abs, aba, stp, cli, cle, sdn, ddn, wdn;
	logic [7:0] sfr_addr, sfr_wdata, stat, errf, rdata, eng_d;
	logic [7:0] ctl, siz, dvl, mlp, fid, eng_q;
	logic [2:0] eng_ra;
	logic [7:0] pat [8];
	logic [7:0] expq [$];
	int failures, check_count, cyc;
	lir_indirect_regs dut (
		.i_clk_sys(i_clk_sys),
		.i_nrst(i_nrst),
		.i_sfr_addr(sfr_addr),
		.i_sfr_wdata(sfr_wdata),
		.i_sfr_wr(sfr_wr),
		.i_sfr_rd(sfr_rd),
		.o_sfr_rdata(rdata),
		.o_sfr_rvalid(rvalid),
		.o_controller_enable(en),
		.o_master_mode(mst),
		.o_auto_baud_select(abs),
		.o_auto_baud_active(aba),
		.o_frame_control(ctl),
		.o_stop_strobe(stp),
		.o_clear_interrupt_strobe(cli),
		.o_clear_error_strobe(cle),
		.i_streq_done(sdn),
		.i_dtack_done(ddn),
		.i_wupreq_done(wdn),
		.i_frame_status(stat),
		.i_frame_error_flags(errf),
		.o_frame_length_checksum(siz),
		.o_baud_divider_low(dvl),
		.o_baud_multiplier_prescale(mlp),
		.o_frame_identifier(fid),
		.i_eng_rd_addr(eng_ra),
		.o_eng_rd_data(eng_q),
		.i_eng_wr(eng_wr),
		.i_eng_wr_addr(3'h2),
		.i_eng_wr_data(eng_d)
	);
	task automatic complete_run;
		if (failures == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		check_count++;
		if (g !== e)
		begin
			failures++;
			$display("CHECK FAILED %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, d);
		@(negedge i_clk_sys);
		sfr_wr = w;
		sfr_rd = !w;
		sfr_addr = a;
		sfr_wdata = d;
	endtask
	// Read answers are queued here and matched by the watcher below
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h00);
		expq.push_back(e);
	endtask
	always @(negedge i_clk_sys)
		if (rvalid === 1'b1)
		begin
			if (expq.size() == 0)
			begin
				failures++;
				$display("CHECK FAILED %0t read answer with no request", $time);
			end
			else
				chk(rdata, expq.pop_front());
		end
	always @(posedge i_clk_sys)
	begin
		cyc++;
		if (cyc > 3000)
		begin
			failures++;
			complete_run;
		end
	end
	initial
	begin
		i_clk_sys = 0;
		forever #5 i_clk_sys = ~i_clk_sys;
	end
	initial
	begin
		i_nrst = 0;
		sfr_wr = 0;
		sfr_rd = 0;
		sfr_addr = 8'h00;
		sfr_wdata = 8'h00;
		eng_wr = 0;
		sdn = 0;
		ddn = 0;
		wdn = 0;
		eng_ra = 3'h0;
		void'($urandom(7));
		// slave access while request pends, bus idle
		stat = (8'($urandom) & 8'h6f) | 8'h10;
		errf = $urandom;
		eng_d = $urandom;
		repeat (10) @(posedge i_clk_sys);
		@(negedge i_clk_sys);
		i_nrst = 1;
		rd(8'hc9, 8'h60);
		rd(8'hd3, 8'h00);
		rd(8'hd2, 8'h00);
		for (int i = 0; i < 8; i++)
		begin
			pat[i] = $urandom;
			bus(1'b1, 8'hd3, i[7:0]);
			bus(1'b1, 8'hd2, pat[i]);
		end
		for (int i = 7; i >= 0; i--)
		begin
			bus(1'b1, 8'hd3, i[7:0]);
			rd(8'hd2, pat[i]);
		end
		@(negedge i_clk_sys);
		sfr_rd = 0;
		eng_wr = 1;
		eng_ra = 3'h5;
		bus(1'b1, 8'hd3, 8'h02);
		eng_wr = 0;
		chk(eng_q, pat[5]);
		rd(8'hd2, eng_d);
		eng_ra = 3'h2;
		bus(1'b1, 8'hd3, 8'h0f | 8'($urandom));
		chk(eng_q, eng_d);
		bus(1'b1, 8'hd2, 8'hff);
		rd(8'hd2, 8'h00);
		rd(8'h55, 8'h00);
		bus(1'b1, 8'hc9, 8'hff);
		rd(8'hc9, 8'he0);
		bus(1'b1, 8'hc9, 8'ha0);
		rd(8'hc9, 8'ha0);
		chk({en, mst, abs, aba, 4'h0}, 8'hb0);
		bus(1'b1, 8'hd3, 8'h08);
		bus(1'b1, 8'hd2, 8'hff);
		rd(8'hd2, 8'h72);
		chk({5'h0, stp, cli, cle}, 8'h07);
		chk(ctl, 8'h72);
		bus(1'b1, 8'hd3, 8'h09);
		chk({5'h0, stp, cli, cle}, 8'h00);
		ddn = 1;
		wdn = 1;
		rd(8'hd2, stat);
		ddn = 0;
		wdn = 0;
		chk(ctl, 8'h60);
		bus(1'b1, 8'hd3, 8'h0a);
		rd(8'hd2, errf & 8'h1f);
		bus(1'b1, 8'hc9, 8'hc0);
		rd(8'hd2, errf & 8'h07);
		bus(1'b1, 8'hd3, 8'h09);
		rd(8'hd2, stat & 8'hcf);
		bus(1'b1, 8'hd3, 8'h08);
		rd(8'hd2, 8'h20);
		bus(1'b1, 8'hd2, 8'h8d);
		sdn = 1;
		rd(8'hd2, 8'h01);
		sdn = 0;
		chk(ctl, 8'h41);
		chk({5'h0, stp, cli, cle}, 8'h03);
		for (int i = 11; i < 15; i++)
		begin
			bus(1'b1, 8'hd3, i[7:0]);
			bus(1'b1, 8'hd2, 8'hff);
			rd(8'hd2, i == 11 ? 8'h8f : i == 14 ? 8'h3f : 8'hff);
		end
		chk(siz, 8'h8f);
		chk(dvl, 8'hff);
		chk(mlp, 8'hff);
		chk(fid, 8'h3f);
		bus(1'b1, 8'h00, 8'h00);
		@(negedge i_clk_sys);
		sfr_wr = 0;
		repeat (4) @(negedge i_clk_sys);
		chk(8'(expq.size()), 8'h00);
		// Mid-run reset must restore every register
		i_nrst = 0;
		@(negedge i_clk_sys);
		i_nrst = 1;
		chk({en, mst, abs, aba, 4'h0}, 8'h60);
		chk(fid | siz | dvl | mlp | ctl | eng_q, 8'h00);
		rd(8'hd3, 8'h00);
		bus(1'b1, 8'hd3, 8'h05);
		rd(8'hd2, 8'h00);
		@(negedge i_clk_sys);
		sfr_rd = 0;
		repeat (4) @(negedge i_clk_sys);
		chk(8'(expq.size()), 8'h00);
		complete_run;
	end
endmodule
`default_nettype wire
